// File: devparam_pkg.sv
/*
  Package for the general device parameter register bank: register
  numbers, mode codes, status bit positions, reset values.
  Assumes nothing of its surroundings.
*/
package devparam_pkg;
  localparam logic [15:0] REG_OPERATING_MODE = 16'h0001;
  localparam logic [15:0] REG_STATUS_LOW = 16'h0002;
  localparam logic [15:0] REG_STATUS_HIGH = 16'h0003;
  localparam logic [15:0] REG_SLAVE_ADDRESS = 16'h0004;
  localparam logic [15:0] MODE_RUN_A = 16'h0000;
  localparam logic [15:0] MODE_RUN_B = 16'h0001;
  localparam logic [15:0] MODE_FACTORY_RESET = 16'h0002;
  localparam logic [15:0] MODE_MODULE_RESET = 16'h0003;
  localparam logic [15:0] MODE_RESET_VALUE = 16'h0000;
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hF7;
  localparam logic [7:0] ADDR_DEFAULT = 8'h01;
  localparam int ST_FIELDBUS_RUN = 0;
  localparam int ST_SHIFT_MASTER_RUN = 1;
  localparam int ST_SYNC_MAP_ERR = 2;
  localparam int ST_PORT_MAP_ERR = 3;
  localparam int ST_FIELDBUS_MAP_ERR = 4;
  localparam int ST_SHIFT_CFG_ERR = 5;
  localparam int ST_PORT_CFG_ERR = 6;
  localparam int ST_FIELDBUS_CFG_ERR = 7;
  localparam int ST_EXT_MAP_ERR = 14;
  localparam int ST_SCRIPT_RUN = 15;
  localparam int ST_SCRIPT_ERR = 16;
  localparam logic [31:0] STATUS_RESERVED_MASK = 32'hFFFE3F00;
endpackage : devparam_pkg

// File: device_mode_status_regs.sv
/*
  General device parameter registers: operating mode, 32-bit module
  status as two words, persistent slave address for the serial data port.
  Assumes a protocol engine on CLK that issues single-cycle register
  reads and writes, a persistent store that loads and saves the address,
  and status inputs from the rest of the module.
*/
`timescale 1ns/1ns
`default_nettype none
module device_mode_status_regs
  import devparam_pkg::*;
(
  // clock, reset, enable
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  // register access
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  output logic REG_ACK,
  output logic REG_ERR,
  // persistent store
  input wire logic STORE_VALID,
  input wire logic [7:0] STORE_ADDRESS,
  output logic STORE_SAVE,
  output logic [7:0] STORE_SAVE_ADDRESS,
  output logic FACTORY_RESTORE,
  // module reset control
  output logic MODULE_RESET,
  output logic INIT_ACTIVE,
  input wire logic INIT_DONE,
  // status sources
  input wire logic FIELDBUS_RUN,
  input wire logic SHIFT_MASTER_RUN,
  input wire logic SYNC_MAP_ERR,
  input wire logic PORT_MAP_ERR,
  input wire logic FIELDBUS_MAP_ERR,
  input wire logic SHIFT_CFG_ERR,
  input wire logic PORT_CFG_ERR,
  input wire logic FIELDBUS_CFG_ERR,
  input wire logic EXT_MAP_ERR,
  input wire logic SCRIPT_RUN,
  input wire logic SCRIPT_ERR,
  // request frame filter
  input wire logic FRAME_FIRST_VALID,
  input wire logic [7:0] FRAME_FIRST_BYTE,
  output logic FRAME_ACCEPT,
  output logic [7:0] ACTIVE_ADDRESS
);
  typedef enum logic [1:0] {ST_INIT, ST_RUN, ST_RESTORE, ST_RESET} phase_e;

  phase_e phase;
  logic [15:0] operating_mode;
  logic [7:0] serial_slave_address;
  logic shift_cfg_err_latched;
  logic script_err_sticky;
  logic [31:0] status_word;

  // decode
  wire hit_mode = REG_ADDR == REG_OPERATING_MODE;
  wire hit_low = REG_ADDR == REG_STATUS_LOW;
  wire hit_high = REG_ADDR == REG_STATUS_HIGH;
  wire hit_addr = REG_ADDR == REG_SLAVE_ADDRESS;
  wire mapped = hit_mode | hit_low | hit_high | hit_addr;
  wire req = CLK_EN & (REG_WR | REG_RD) & phase == ST_RUN;
  wire mode_ok = REG_WDATA <= MODE_MODULE_RESET;
  wire addr_ok = REG_WDATA[15:8] == 8'h00 && REG_WDATA[7:0] >= ADDR_MIN && REG_WDATA[7:0] <= ADDR_MAX;
  wire wr_mode = req & REG_WR & hit_mode & mode_ok;
  wire wr_addr = req & REG_WR & hit_addr & addr_ok;
  wire bad_wr = REG_WR & ((hit_mode & ~mode_ok) | (hit_addr & ~addr_ok) | hit_low | hit_high);
  wire go_restore = wr_mode & REG_WDATA == MODE_FACTORY_RESET;
  wire go_reset = wr_mode & REG_WDATA == MODE_MODULE_RESET;
  // a corrupt stored value is ignored, the last good copy stays
  wire store_ok = STORE_ADDRESS >= ADDR_MIN && STORE_ADDRESS <= ADDR_MAX;
  wire store_load = phase == ST_INIT && STORE_VALID && store_ok;
  // same-edge value, so even a one-cycle init picks up the stored address
  wire [7:0] init_address = store_load ? STORE_ADDRESS : serial_slave_address;

  // status assembly, reserved bits zero
  always_comb
  begin
    status_word = 32'h00000000;
    status_word[ST_FIELDBUS_RUN] = FIELDBUS_RUN;
    status_word[ST_SHIFT_MASTER_RUN] = SHIFT_MASTER_RUN;
    status_word[ST_SYNC_MAP_ERR] = SYNC_MAP_ERR;
    status_word[ST_PORT_MAP_ERR] = PORT_MAP_ERR;
    status_word[ST_FIELDBUS_MAP_ERR] = FIELDBUS_MAP_ERR;
    status_word[ST_EXT_MAP_ERR] = EXT_MAP_ERR;
    status_word[ST_SHIFT_CFG_ERR] = shift_cfg_err_latched;
    status_word[ST_PORT_CFG_ERR] = PORT_CFG_ERR;
    status_word[ST_FIELDBUS_CFG_ERR] = FIELDBUS_CFG_ERR;
    status_word[ST_SCRIPT_RUN] = SCRIPT_RUN;
    status_word[ST_SCRIPT_ERR] = script_err_sticky;
  end

  // read mux; little endian storage is invisible at word granularity
  wire [15:0] next_rdata = hit_mode ? operating_mode :
                           hit_low ? status_word[15:0] :
                           hit_high ? status_word[31:16] :
                           hit_addr ? {8'h00, serial_slave_address} : 16'h0000;

  // phase sequencing
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      phase <= ST_INIT;
    else if (CLK_EN)
    begin
      case (phase)
        ST_INIT: if (INIT_DONE) phase <= ST_RUN;
        ST_RUN: if (go_restore) phase <= ST_RESTORE; else if (go_reset) phase <= ST_RESET;
        ST_RESTORE: phase <= ST_RESET;
        ST_RESET: phase <= ST_INIT;
        default: phase <= ST_INIT;
      endcase
    end
  end

  // operating mode; returns to run after each module reset
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      operating_mode <= MODE_RESET_VALUE;
    else if (CLK_EN)
    begin
      if (phase == ST_RESET)
        operating_mode <= MODE_RESET_VALUE;
      else if (wr_mode)
        operating_mode <= REG_WDATA;
    end
  end

  // stored address: software copy, saved to persistent store
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      serial_slave_address <= ADDR_DEFAULT;
    else if (CLK_EN)
    begin
      if (phase == ST_RESTORE)
        serial_slave_address <= ADDR_DEFAULT;
      else if (store_load)
        serial_slave_address <= STORE_ADDRESS;
      else if (wr_addr)
        serial_slave_address <= REG_WDATA[7:0];
    end
  end

  // active address: loaded only at the end of initialisation
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      ACTIVE_ADDRESS <= ADDR_DEFAULT;
    else if (CLK_EN && phase == ST_INIT && INIT_DONE)
      ACTIVE_ADDRESS <= init_address;
  end

  // bit 5 frozen outside init so late errors cannot show
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      shift_cfg_err_latched <= 1'b0;
    else if (CLK_EN && phase == ST_INIT)
      shift_cfg_err_latched <= SHIFT_CFG_ERR;
  end

  // script error holds until a module reset
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      script_err_sticky <= 1'b0;
    else if (CLK_EN)
    begin
      if (SCRIPT_ERR)
        script_err_sticky <= 1'b1;
      else if (phase == ST_RESET)
        script_err_sticky <= 1'b0;
    end
  end

  // bus answers and store strobes
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      REG_RDATA <= 16'h0000;
      REG_ACK <= 1'b0;
      REG_ERR <= 1'b0;
      STORE_SAVE <= 1'b0;
      STORE_SAVE_ADDRESS <= ADDR_DEFAULT;
      FRAME_ACCEPT <= 1'b0;
    end
    else if (CLK_EN)
    begin
      REG_ACK <= req;
      REG_ERR <= req & (~mapped | bad_wr);
      if (req & REG_RD)
        REG_RDATA <= next_rdata;
      STORE_SAVE <= wr_addr | phase == ST_RESTORE;
      if (wr_addr)
        STORE_SAVE_ADDRESS <= REG_WDATA[7:0];
      else if (phase == ST_RESTORE)
        STORE_SAVE_ADDRESS <= ADDR_DEFAULT;
      FRAME_ACCEPT <= FRAME_FIRST_VALID && FRAME_FIRST_BYTE == ACTIVE_ADDRESS && phase == ST_RUN;
    end
  end

  assign FACTORY_RESTORE = phase == ST_RESTORE;
  assign MODULE_RESET = phase == ST_RESET;
  assign INIT_ACTIVE = phase == ST_INIT;

  // checks
  property p_mode_reset;
    @(posedge CLK) disable iff (!RESET_N)
    CLK_EN && go_reset |=> MODULE_RESET;
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("module reset missing after code 3");

  sequence s_restore_step;
    FACTORY_RESTORE && CLK_EN;
  endsequence
  sequence s_reset_step;
    MODULE_RESET && CLK_EN;
  endsequence
  property p_factory;
    @(posedge CLK) disable iff (!RESET_N)
    CLK_EN && go_restore |=> FACTORY_RESTORE;
  endproperty
  a_factory: assert property (p_factory) else $error("factory restore missing after code 2");

  property p_restore_reset;
    @(posedge CLK) disable iff (!RESET_N)
    s_restore_step |=> MODULE_RESET && !FACTORY_RESTORE;
  endproperty
  a_restore_reset: assert property (p_restore_reset) else $error("factory restore not followed by reset");

  property p_reset_init;
    @(posedge CLK) disable iff (!RESET_N)
    s_reset_step |=> INIT_ACTIVE && operating_mode == MODE_RESET_VALUE;
  endproperty
  a_reset_init: assert property (p_reset_init) else $error("module reset did not reinitialise");

  property p_mode_range;
    @(posedge CLK) disable iff (!RESET_N)
    operating_mode <= MODE_MODULE_RESET;
  endproperty
  a_mode_range: assert property (p_mode_range) else $error("operating mode out of range");

  property p_addr_range;
    @(posedge CLK) disable iff (!RESET_N)
    serial_slave_address >= ADDR_MIN && serial_slave_address <= ADDR_MAX;
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("slave address out of range");

  property p_active_stable;
    @(posedge CLK) disable iff (!RESET_N)
    phase == ST_RUN |=> $stable(ACTIVE_ADDRESS);
  endproperty
  a_active_stable: assert property (p_active_stable) else $error("active address changed in run");

  property p_cfg_frozen;
    @(posedge CLK) disable iff (!RESET_N)
    phase != ST_INIT |=> $stable(shift_cfg_err_latched);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen) else $error("bit 5 changed after init");

  property p_read_high;
    @(posedge CLK) disable iff (!RESET_N)
    req && REG_RD && hit_high |=> REG_RDATA == $past(status_word[31:16]);
  endproperty
  a_read_high: assert property (p_read_high) else $error("high status word wrong");

  property p_reserved_read;
    @(posedge CLK) disable iff (!RESET_N)
    req && REG_RD && hit_low |=> (REG_RDATA & STATUS_RESERVED_MASK[15:0]) == 16'h0000;
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved bits read as one");

  property p_store_save;
    @(posedge CLK) disable iff (!RESET_N)
    wr_addr |=> STORE_SAVE && STORE_SAVE_ADDRESS == $past(REG_WDATA[7:0]);
  endproperty
  a_store_save: assert property (p_store_save) else $error("written address not saved");

  property p_reserved;
    @(posedge CLK) disable iff (!RESET_N)
    (status_word & STATUS_RESERVED_MASK) == 32'h00000000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved status bits set");

  property p_filter;
    @(posedge CLK) disable iff (!RESET_N)
    CLK_EN && FRAME_FIRST_BYTE != ACTIVE_ADDRESS |=> !FRAME_ACCEPT;
  endproperty
  a_filter: assert property (p_filter) else $error("foreign frame accepted");

  property p_script_err;
    @(posedge CLK) disable iff (!RESET_N)
    CLK_EN && SCRIPT_ERR |=> status_word[ST_SCRIPT_ERR];
  endproperty
  a_script_err: assert property (p_script_err) else $error("script error not flagged");
endmodule : device_mode_status_regs
`default_nettype wire

// File: devparam_store_model.sv
/*
  Persistent store model for the slave address, with init handshake.
  Assumes the register bank's store and init ports on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module devparam_store_model
  import devparam_pkg::*;
(
  // clock
  input wire logic CLK,
  // store side
  input wire logic STORE_SAVE,
  input wire logic [7:0] STORE_SAVE_ADDRESS,
  input wire logic FACTORY_RESTORE,
  output logic STORE_VALID,
  output logic [7:0] STORE_ADDRESS,
  // init handshake
  input wire logic INIT_ACTIVE,
  output logic INIT_DONE
);
  // no reset input: contents survive a module reset
  logic [7:0] mem = ADDR_DEFAULT;
  logic [1:0] wait_cnt = 2'h0;
  assign STORE_VALID = 1'b1;
  assign STORE_ADDRESS = mem;
  // slow answer, so init spans several cycles
  assign INIT_DONE = (wait_cnt == 2'h3);
  always @(posedge CLK)
  begin
    if (FACTORY_RESTORE)
      mem <= ADDR_DEFAULT;
    else if (STORE_SAVE)
      mem <= STORE_SAVE_ADDRESS;
    wait_cnt <= (INIT_ACTIVE && wait_cnt != 2'h3) ? wait_cnt + 2'h1 : 2'h0;
  end
endmodule : devparam_store_model
`default_nettype wire

// File: device_mode_status_regs_tb.sv
/*
  Self-checking bench for the device parameter registers.
  Assumes the store model answers init and keeps the address.
*/
`timescale 1ns/1ns
`default_nettype none
module device_mode_status_regs_tb;
  import devparam_pkg::*;
  logic CLK = 0, RESET_N = 0, REG_WR = 0, REG_RD = 0, FRAME_FIRST_VALID = 0, CLK_EN = 1;
  logic [15:0] REG_ADDR = 16'h0000, REG_WDATA = 16'h0000, REG_RDATA, rd_val;
  logic REG_ACK, REG_ERR, err_val, STORE_SAVE, FACTORY_RESTORE, MODULE_RESET;
  logic INIT_ACTIVE, INIT_DONE, STORE_VALID, FRAME_ACCEPT, acc_val;
  logic [7:0] FRAME_FIRST_BYTE = 8'h00, STORE_ADDRESS, STORE_SAVE_ADDRESS, ACTIVE_ADDRESS;
  logic [10:0] st = 11'h000;
  logic seen_save = 0, seen_mr = 0, seen_fr = 0;
  int n_mismatch = 0, checks = 0, cycles = 0;
  device_mode_status_regs dut_u (.CLK(CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK), .REG_ERR(REG_ERR), .STORE_VALID(STORE_VALID),
    .STORE_ADDRESS(STORE_ADDRESS), .STORE_SAVE(STORE_SAVE), .STORE_SAVE_ADDRESS(STORE_SAVE_ADDRESS),
    .FACTORY_RESTORE(FACTORY_RESTORE), .MODULE_RESET(MODULE_RESET), .INIT_ACTIVE(INIT_ACTIVE),
    .INIT_DONE(INIT_DONE), .FIELDBUS_RUN(st[0]), .SHIFT_MASTER_RUN(st[1]), .SYNC_MAP_ERR(st[2]),
    .PORT_MAP_ERR(st[3]), .FIELDBUS_MAP_ERR(st[4]), .SHIFT_CFG_ERR(st[5]), .PORT_CFG_ERR(st[6]),
    .FIELDBUS_CFG_ERR(st[7]), .EXT_MAP_ERR(st[8]), .SCRIPT_RUN(st[9]), .SCRIPT_ERR(st[10]),
    .FRAME_FIRST_VALID(FRAME_FIRST_VALID), .FRAME_FIRST_BYTE(FRAME_FIRST_BYTE),
    .FRAME_ACCEPT(FRAME_ACCEPT), .ACTIVE_ADDRESS(ACTIVE_ADDRESS));
  devparam_store_model store_u (.CLK(CLK), .STORE_SAVE(STORE_SAVE),
    .STORE_SAVE_ADDRESS(STORE_SAVE_ADDRESS), .FACTORY_RESTORE(FACTORY_RESTORE),
    .STORE_VALID(STORE_VALID), .STORE_ADDRESS(STORE_ADDRESS), .INIT_ACTIVE(INIT_ACTIVE),
    .INIT_DONE(INIT_DONE));
  initial
    forever #4 CLK = ~CLK;
  task tally_and_finish;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one-cycle strobe, answer read at the negedge half a cycle after the taking edge
  task acc(input logic wr, input logic [15:0] a, input logic [15:0] d);
    REG_WR = wr;
    REG_RD = !wr;
    REG_ADDR = a;
    REG_WDATA = d;
    @(negedge CLK);
    REG_WR = 0;
    REG_RD = 0;
    chk(16'(REG_ACK), 16'h0001);
    rd_val = REG_RDATA;
    err_val = REG_ERR;
    @(negedge CLK);
  endtask : acc
  task frame(input logic [7:0] b);
    FRAME_FIRST_VALID = 1;
    FRAME_FIRST_BYTE = b;
    @(negedge CLK);
    FRAME_FIRST_VALID = 0;
    acc_val = FRAME_ACCEPT;
    @(negedge CLK);
    acc_val = acc_val | FRAME_ACCEPT;
  endtask : frame
  task wait_run;
    repeat (4) if (!INIT_ACTIVE) @(negedge CLK);
    repeat (40) if (INIT_ACTIVE) @(negedge CLK);
    chk(16'(INIT_ACTIVE), 16'h0000);
  endtask : wait_run
  always @(posedge CLK)
  begin
    seen_save |= STORE_SAVE;
    seen_mr |= MODULE_RESET;
    seen_fr |= FACTORY_RESTORE;
    cycles++;
    // far above the hundred or so cycles the sequence needs
    if (cycles == 3000)
    begin
      n_mismatch++;
      tally_and_finish;
    end
  end
  initial
  begin
    repeat (16) @(negedge CLK);
    RESET_N = 1;
    wait_run;
    acc(0, REG_OPERATING_MODE, 16'h0000);
    chk(rd_val, MODE_RESET_VALUE);
    acc(0, REG_SLAVE_ADDRESS, 16'h0000);
    chk(rd_val, 16'(ADDR_DEFAULT));
    acc(1, REG_OPERATING_MODE, MODE_RUN_B);
    chk(16'(err_val), 16'h0000);
    acc(1, REG_OPERATING_MODE, 16'h0004);
    chk(16'(err_val), 16'h0001);
    acc(0, REG_OPERATING_MODE, 16'h0000);
    chk(rd_val, MODE_RUN_B);
    acc(1, REG_OPERATING_MODE, MODE_RUN_A);
    chk(16'(err_val), 16'h0000);
    // enable low: a reset code must not be taken
    CLK_EN = 0;
    REG_WR = 1;
    REG_ADDR = REG_OPERATING_MODE;
    REG_WDATA = MODE_MODULE_RESET;
    @(negedge CLK);
    REG_WR = 0;
    chk(16'(REG_ACK), 16'h0000);
    CLK_EN = 1;
    @(negedge CLK);
    chk(16'(INIT_ACTIVE), 16'h0000);
    acc(0, REG_OPERATING_MODE, 16'h0000);
    chk(rd_val, MODE_RUN_A);
    acc(1, REG_STATUS_LOW, 16'hFFFF);
    chk(16'(err_val), 16'h0001);
    acc(0, 16'h0005, 16'h0000);
    chk(16'(err_val), 16'h0001);
    // bit 5 raised only after init must not show
    st = 11'h375;
    acc(0, REG_STATUS_LOW, 16'h0000);
    chk(rd_val, 16'hC055);
    st = 11'h0AA;
    acc(0, REG_STATUS_LOW, 16'h0000);
    chk(rd_val, 16'h008A);
    st[10] = 1;
    @(negedge CLK);
    st[10] = 0;
    acc(0, REG_STATUS_HIGH, 16'h0000);
    chk(rd_val, 16'h0001);
    acc(1, REG_SLAVE_ADDRESS, 16'h000A);
    chk(16'({err_val, seen_save}), 16'h0001);
    acc(1, REG_SLAVE_ADDRESS, 16'h00F8);
    chk(16'(err_val), 16'h0001);
    chk(16'(STORE_SAVE_ADDRESS), 16'h000A);
    chk(16'(ACTIVE_ADDRESS), 16'h0001);
    frame(8'h0A);
    chk(16'(acc_val), 16'h0000);
    frame(8'h01);
    chk(16'(acc_val), 16'h0001);
    acc(1, REG_OPERATING_MODE, MODE_MODULE_RESET);
    wait_run;
    chk(16'(seen_mr), 16'h0001);
    chk(16'(ACTIVE_ADDRESS), 16'h000A);
    acc(0, REG_OPERATING_MODE, 16'h0000);
    chk(rd_val, MODE_RESET_VALUE);
    acc(0, REG_STATUS_LOW, 16'h0000);
    chk(rd_val, 16'h00AA);
    acc(0, REG_STATUS_HIGH, 16'h0000);
    chk(rd_val, 16'h0000);
    frame(8'h0A);
    chk(16'(acc_val), 16'h0001);
    acc(1, REG_OPERATING_MODE, MODE_FACTORY_RESET);
    wait_run;
    chk(16'(seen_fr), 16'h0001);
    chk(16'(ACTIVE_ADDRESS), 16'(ADDR_DEFAULT));
    acc(1, REG_SLAVE_ADDRESS, 16'h000B);
    chk(16'(STORE_SAVE_ADDRESS), 16'h000B);
    // power cycle: the store keeps the address across it
    RESET_N = 0;
    repeat (4) @(negedge CLK);
    RESET_N = 1;
    wait_run;
    chk(16'(ACTIVE_ADDRESS), 16'h000B);
    acc(0, REG_SLAVE_ADDRESS, 16'h0000);
    chk(rd_val, 16'h000B);
    tally_and_finish;
  end
endmodule : device_mode_status_regs_tb
`default_nettype wire
